// ---- uie_pkg.sv ----
/*
 * Constants for the UART interrupt mask, source status and FIFO control block.
 * Assumes a single 125 MHz clock and a plain strobe register port.
 */
package uie_pkg;
    // Register indices on the local port
    localparam logic [2:0] ADDR_RX_DATA = 3'h0;
    localparam logic [2:0] ADDR_MASK = 3'h1;
    localparam logic [2:0] ADDR_SOURCE = 3'h2;
    localparam logic [2:0] ADDR_FIFO_CTRL = 3'h2;
    localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
    localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
    localparam logic [2:0] ADDR_ENH_MODE = 3'h7;
    // Interrupt mask fields
    localparam int MASK_RX = 0;
    localparam int MASK_TX = 1;
    localparam int MASK_LINE = 2;
    localparam int MASK_MODEM = 3;
    localparam int MASK_SLEEP = 4;
    localparam int MASK_XOFF = 5;
    localparam int MASK_RTS = 6;
    localparam int MASK_CTS = 7;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] MASK_LOW_BITS = 8'h0F;
    // FIFO control and enhanced mode fields
    localparam int FC_ENABLE = 0;
    localparam int FC_WAKE = 3;
    localparam int FC_TX_TRIG_LO = 4;
    localparam int FC_RX_TRIG_LO = 6;
    localparam int EMS_LINE_SEL = 6;
    // Source codes, bits 5..0
    localparam logic [5:0] CODE_LINE = 6'h06;
    localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
    localparam logic [5:0] CODE_RX = 6'h04;
    localparam logic [5:0] CODE_TX = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_CHAR = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;
    localparam logic [5:0] CODE_NONE = 6'h01;
    // Trigger tables
    localparam logic [5:0] RX_TRIG_0 = 6'h08;
    localparam logic [5:0] RX_TRIG_1 = 6'h10;
    localparam logic [5:0] RX_TRIG_2 = 6'h18;
    localparam logic [5:0] RX_TRIG_3 = 6'h1C;
    localparam logic [5:0] TX_TRIG_0 = 6'h10;
    localparam logic [5:0] TX_TRIG_1 = 6'h08;
    localparam logic [5:0] TX_TRIG_2 = 6'h18;
    localparam logic [5:0] TX_TRIG_3 = 6'h1E;
    // Timeout span: four characters plus twelve bits, in bit times
    localparam int TIMEOUT_CHARS = 4;
    localparam int TIMEOUT_BITS = 12;
    typedef enum logic [2:0] {
        UIE_SRC_NONE, UIE_SRC_LINE, UIE_SRC_TIMEOUT, UIE_SRC_RX,
        UIE_SRC_TX, UIE_SRC_MODEM, UIE_SRC_CHAR, UIE_SRC_FLOW
    } uie_src_e;
endpackage : uie_pkg

// ---- uie_core.sv ----
/*
 * Interrupt mask, priority encoding, source status and clearing of a FIFO UART,
 * plus FIFO control and line status bits that feed them.
 * Assumes the receiver, transmitter, FIFOs and modem unit give synchronous levels
 * and one-cycle event pulses; a bit time arrives as a one-cycle enable pulse.
 */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - FIFO receive interrupt follows trigger level
// - Data ready set on push, cleared empty
// - All mask bits clear gives polled mode, bar wakeup and an already pending flow source
// - Line status bits report rx, tx state
// - Receive interrupt on data or trigger
// - Transmit interrupt on empty, trigger, enable
// - Line interrupt on overrun or errored char
// - Modem interrupt on any change bit
// - Upper mask bits need enhanced enable
// - Flow pin rising edge interrupt
// - Status read gives highest pending code
// - Codes for priorities one to four
// - Codes for priorities five to seven
// - Timeout after four chars twelve bits
// - Transmit interrupt cleared by read or write
// - Line, modem reads clear their interrupts
// - Status read clears char interrupts
// - Wakeup interrupt cleared by status read
// - Bit zero low while pending, except wakeup
// - Bits four, five flag char, flow
// - Bits seven, six show FIFO enable
// - FIFO enable gates other control bits
// - Receive trigger 8, 16, 24, 28
// - Transmit trigger 16, 8, 24, 30
module uie_core #(
    parameter int CHAR_BITS = 10,
    parameter int LVL_W = 6
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic enh_enable,
    input wire logic [LVL_W-1:0] rx_level,
    input wire logic [LVL_W-1:0] tx_level,
    input wire logic rx_push,
    input wire logic rx_char_tick,
    input wire logic bit_tick,
    input wire logic thr_empty,
    input wire logic tx_all_empty,
    input wire logic overrun_evt,
    input wire logic [2:0] head_errors,
    input wire logic push_errored,
    input wire logic fifo_has_error,
    input wire logic [3:0] modem_changes,
    input wire logic char_match_evt,
    input wire logic special_char_evt,
    input wire logic auto_rts,
    input wire logic auto_cts,
    input wire logic rts_pin,
    input wire logic cts_pin,
    input wire logic wake_evt,
    output logic fifo_enable,
    output logic [1:0] rx_trig_sel,
    output logic [1:0] tx_trig_sel,
    output logic sleep_enable,
    output logic wake_int_enable,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    localparam int TO_BITS = uie_pkg::TIMEOUT_CHARS * CHAR_BITS + uie_pkg::TIMEOUT_BITS;

    logic [7:0] mask, next_mask;
    logic fifo_en, next_fifo_en;
    logic [1:0] rx_sel, next_rx_sel, tx_sel, next_tx_sel;
    logic wake_en, next_wake_en, line_sel, next_line_sel;
    logic line_p, next_line_p, tx_p, next_tx_p, to_p, next_to_p;
    logic char_p, next_char_p, flow_p, next_flow_p, wake_p, next_wake_p;
    logic [3:0] modem_p, next_modem_p;
    logic overrun, next_overrun;
    logic rts_d, cts_d, next_rts_d, next_cts_d;
    logic [7:0] to_cnt, next_to_cnt;
    logic [LVL_W-1:0] rx_trig, tx_trig;
    logic data_ready, rx_p, err_now;
    logic [7:0] src_reg, line_reg, next_rdata;
    logic [5:0] code;
    uie_pkg::uie_src_e top;
    logic rd_src, rd_line, rd_modem, rd_rx, wr_mask, wr_fc, wr_tx;

    assign rd_src = rd && addr == uie_pkg::ADDR_SOURCE;
    assign rd_line = rd && addr == uie_pkg::ADDR_LINE_STATUS;
    assign rd_modem = rd && addr == uie_pkg::ADDR_MODEM_STATUS;
    assign rd_rx = rd && addr == uie_pkg::ADDR_RX_DATA;
    assign wr_mask = wr && addr == uie_pkg::ADDR_MASK;
    assign wr_fc = wr && addr == uie_pkg::ADDR_FIFO_CTRL;
    assign wr_tx = wr && addr == uie_pkg::ADDR_RX_DATA;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger tables
    always_comb begin
        case (rx_sel)
            2'h0: rx_trig = LVL_W'(uie_pkg::RX_TRIG_0);
            2'h1: rx_trig = LVL_W'(uie_pkg::RX_TRIG_1);
            2'h2: rx_trig = LVL_W'(uie_pkg::RX_TRIG_2);
            default: rx_trig = LVL_W'(uie_pkg::RX_TRIG_3);
        endcase
        case (tx_sel)
            2'h0: tx_trig = LVL_W'(uie_pkg::TX_TRIG_0);
            2'h1: tx_trig = LVL_W'(uie_pkg::TX_TRIG_1);
            2'h2: tx_trig = LVL_W'(uie_pkg::TX_TRIG_2);
            default: tx_trig = LVL_W'(uie_pkg::TX_TRIG_3);
        endcase
    end

    // Receive level interrupt is a live level, so it drops with the FIFO
    assign data_ready = rx_level != '0;
    assign rx_p = fifo_en ? (rx_level >= rx_trig) : data_ready;
    assign err_now = line_sel ? push_errored : (head_errors != 3'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_comb begin
        next_mask = mask;
        next_fifo_en = fifo_en;
        next_rx_sel = rx_sel;
        next_tx_sel = tx_sel;
        next_wake_en = wake_en;
        next_line_sel = line_sel;
        if (wr_mask) begin
            // Upper half locked unless enhanced functions are enabled
            next_mask[3:0] = wdata[3:0];
            if (enh_enable) begin
                next_mask[7:4] = wdata[7:4];
            end
        end else if (wr_fc) begin
            next_fifo_en = wdata[uie_pkg::FC_ENABLE];
            if (wdata[uie_pkg::FC_ENABLE]) begin
                next_rx_sel = wdata[uie_pkg::FC_RX_TRIG_LO +: 2];
                if (enh_enable) begin
                    next_tx_sel = wdata[uie_pkg::FC_TX_TRIG_LO +: 2];
                    next_wake_en = wdata[uie_pkg::FC_WAKE];
                end
            end
        end else if (wr && addr == uie_pkg::ADDR_ENH_MODE) begin
            next_line_sel = wdata[uie_pkg::EMS_LINE_SEL];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mask <= uie_pkg::MASK_RESET;
            fifo_en <= 1'b0;
            rx_sel <= 2'h0;
            tx_sel <= 2'h0;
            wake_en <= 1'b0;
            line_sel <= 1'b0;
        end else begin
            mask <= next_mask;
            fifo_en <= next_fifo_en;
            rx_sel <= next_rx_sel;
            tx_sel <= next_tx_sel;
            wake_en <= next_wake_en;
            line_sel <= next_line_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge helpers for the transmit source
    logic thr_d, tx_dec, thr_rise;
    logic [LVL_W-1:0] tx_lvl_d;
    assign thr_rise = thr_empty && !thr_d;
    assign tx_dec = tx_level < tx_lvl_d;

    // Sticky sources; a new event wins over a clearing access, except timeout, where a receive read restarts the timer
    always_comb begin
        next_rts_d = rts_pin;
        next_cts_d = cts_pin;
        next_overrun = overrun_evt ? 1'b1 : (rd_line ? 1'b0 : overrun);
        next_line_p = line_p;
        if (rd_line) next_line_p = 1'b0;
        if (overrun_evt || err_now) next_line_p = 1'b1;
        next_tx_p = tx_p;
        if (rd_src || wr_tx) next_tx_p = 1'b0;
        if (fifo_en ? (tx_level == tx_trig - LVL_W'(1) || tx_level == '0) && tx_dec : thr_rise)
            next_tx_p = 1'b1;
        if (wr_mask && wdata[uie_pkg::MASK_TX] && !mask[uie_pkg::MASK_TX] && thr_empty)
            next_tx_p = 1'b1;
        next_modem_p = rd_modem ? 4'h0 : modem_p;
        next_modem_p = next_modem_p | modem_changes;
        next_char_p = char_p;
        if (rd_src || (rx_push && !char_match_evt)) next_char_p = 1'b0;
        if (char_match_evt || special_char_evt) next_char_p = 1'b1;
        next_flow_p = flow_p;
        if (rd_modem) next_flow_p = 1'b0;
        if ((auto_rts && mask[uie_pkg::MASK_RTS] && rts_pin && !rts_d) ||
            (auto_cts && mask[uie_pkg::MASK_CTS] && cts_pin && !cts_d)) next_flow_p = 1'b1;
        next_wake_p = wake_p;
        if (rd_src) next_wake_p = 1'b0;
        if (wake_evt && wake_en) next_wake_p = 1'b1;
        // Timer restarts on each push or host read, counts bit times while data waits
        next_to_cnt = to_cnt;
        next_to_p = to_p;
        if (rd_rx) next_to_p = 1'b0;
        if (rx_push || rd_rx || !data_ready || !fifo_en) begin
            next_to_cnt = 8'h00;
        end else if (bit_tick && to_cnt != 8'(TO_BITS)) begin
            next_to_cnt = to_cnt + 8'h01;
            if (to_cnt == 8'(TO_BITS - 1)) next_to_p = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            line_p <= 1'b0;
            tx_p <= 1'b0;
            to_p <= 1'b0;
            modem_p <= 4'h0;
            char_p <= 1'b0;
            flow_p <= 1'b0;
            wake_p <= 1'b0;
            overrun <= 1'b0;
            rts_d <= 1'b0;
            cts_d <= 1'b0;
            to_cnt <= 8'h00;
            thr_d <= 1'b1;
            tx_lvl_d <= '0;
        end else begin
            line_p <= next_line_p;
            tx_p <= next_tx_p;
            to_p <= next_to_p;
            modem_p <= next_modem_p;
            char_p <= next_char_p;
            flow_p <= next_flow_p;
            wake_p <= next_wake_p;
            overrun <= next_overrun;
            rts_d <= next_rts_d;
            cts_d <= next_cts_d;
            to_cnt <= next_to_cnt;
            thr_d <= thr_empty;
            tx_lvl_d <= tx_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority encoder: only the top pending enabled source is reported
    always_comb begin
        top = uie_pkg::UIE_SRC_NONE;
        code = uie_pkg::CODE_NONE;
        if (line_p && mask[uie_pkg::MASK_LINE]) begin
            top = uie_pkg::UIE_SRC_LINE;
            code = uie_pkg::CODE_LINE;
        end else if (to_p && mask[uie_pkg::MASK_RX]) begin
            top = uie_pkg::UIE_SRC_TIMEOUT;
            code = uie_pkg::CODE_TIMEOUT;
        end else if (rx_p && mask[uie_pkg::MASK_RX]) begin
            top = uie_pkg::UIE_SRC_RX;
            code = uie_pkg::CODE_RX;
        end else if (tx_p && mask[uie_pkg::MASK_TX]) begin
            top = uie_pkg::UIE_SRC_TX;
            code = uie_pkg::CODE_TX;
        end else if (modem_p != 4'h0 && mask[uie_pkg::MASK_MODEM]) begin
            top = uie_pkg::UIE_SRC_MODEM;
            code = uie_pkg::CODE_MODEM;
        end else if (char_p && mask[uie_pkg::MASK_XOFF] && enh_enable) begin
            top = uie_pkg::UIE_SRC_CHAR;
            code = uie_pkg::CODE_CHAR;
        end else if (flow_p && enh_enable) begin
            top = uie_pkg::UIE_SRC_FLOW;
            code = uie_pkg::CODE_FLOW;
        end
    end

    // Wakeup reports the none code yet still drives the output
    assign irq = (top != uie_pkg::UIE_SRC_NONE) || wake_p;
    assign src_reg = {fifo_en, fifo_en, code};
    assign line_reg = {fifo_has_error, tx_all_empty, thr_empty, head_errors, overrun, data_ready};

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    always_comb begin
        next_rdata = 8'h00;
        if (!rd) begin
            next_rdata = 8'h00;
        end else if (addr == uie_pkg::ADDR_MASK) begin
            next_rdata = mask;
        end else if (addr == uie_pkg::ADDR_SOURCE) begin
            next_rdata = src_reg;
        end else if (addr == uie_pkg::ADDR_LINE_STATUS) begin
            next_rdata = line_reg;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign fifo_enable = fifo_en;
    assign rx_trig_sel = rx_sel;
    assign tx_trig_sel = tx_sel;
    assign sleep_enable = mask[uie_pkg::MASK_SLEEP];
    assign wake_int_enable = wake_en;

    ////////////////////////////////////////////////////////////////////////////
    property p_src_idle;
        @(posedge ref_clk) disable iff (!rstn) rd_src && !irq |=> rdata[0];
    endproperty
    a_src_idle: assert property (p_src_idle) else $error("idle code bit not set");

    property p_fifo_bits;
        @(posedge ref_clk) disable iff (!rstn) rd_src |=> rdata[7:6] == {2{$past(fifo_en)}};
    endproperty
    a_fifo_bits: assert property (p_fifo_bits) else $error("fifo status bits wrong");

    property p_upper_lock;
        @(posedge ref_clk) disable iff (!rstn) wr_mask && !enh_enable |=> $stable(mask[7:4]);
    endproperty
    a_upper_lock: assert property (p_upper_lock) else $error("upper mask written while locked");

    property p_line_first;
        @(posedge ref_clk) disable iff (!rstn) line_p && mask[uie_pkg::MASK_LINE] && rd_src
            |=> rdata[5:0] == uie_pkg::CODE_LINE;
    endproperty
    a_line_first: assert property (p_line_first) else $error("line status not top priority");

    property p_rx_trig;
        @(posedge ref_clk) disable iff (!rstn) fifo_en && mask[uie_pkg::MASK_RX] && rx_level >= rx_trig |-> irq;
    endproperty
    a_rx_trig: assert property (p_rx_trig) else $error("receive trigger missed");

    property p_tx_clear;
        @(posedge ref_clk) disable iff (!rstn) wr_tx && !thr_rise && !(fifo_en && tx_dec) |=> !tx_p;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("transmit source not cleared");

    property p_modem;
        @(posedge ref_clk) disable iff (!rstn) modem_changes != 4'h0 && mask[uie_pkg::MASK_MODEM] |=> irq;
    endproperty
    a_modem: assert property (p_modem) else $error("modem change ignored");

    property p_fc_gate;
        @(posedge ref_clk) disable iff (!rstn) wr_fc && !wdata[uie_pkg::FC_ENABLE] |=> $stable(rx_sel);
    endproperty
    a_fc_gate: assert property (p_fc_gate) else $error("trigger written without enable");

    property p_ready;
        @(posedge ref_clk) disable iff (!rstn) rd_line |=> rdata[0] == ($past(rx_level) != '0);
    endproperty
    a_ready: assert property (p_ready) else $error("data ready bit wrong");

    property p_wake_clear;
        @(posedge ref_clk) disable iff (!rstn) rd_src && !wake_evt |=> !wake_p;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wakeup source not cleared");

    property p_timeout_clear;
        @(posedge ref_clk) disable iff (!rstn) rd_rx |=> !to_p;
    endproperty
    a_timeout_clear: assert property (p_timeout_clear) else $error("timeout source not cleared");

    property p_char_clear;
        @(posedge ref_clk) disable iff (!rstn) rd_src && !char_match_evt && !special_char_evt |=> !char_p;
    endproperty
    a_char_clear: assert property (p_char_clear) else $error("character source not cleared");
endmodule : uie_core

`default_nettype wire

// ---- uie_fifo_model.sv ----
/*
 * Far-side model: fill counts of the receive and transmit FIFOs.
 * Assumes the bench strobes character arrival and transmitter drain.
 */
`timescale 1ns/10ps
`default_nettype none
module uie_fifo_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic rx_char,
    input wire logic rx_take,
    input wire logic tx_put,
    input wire logic tx_shift,
    output logic [5:0] rx_level,
    output logic rx_push,
    output logic [5:0] tx_level,
    output logic thr_empty
);
    logic [5:0] next_rx_level;
    logic [5:0] next_tx_level;
    ////////////////////////////////////////////////////////////
    // Taking from an empty FIFO holds the count at zero instead of wrapping
    always_comb begin
        next_rx_level = rx_level + 6'(rx_char) - 6'(rx_take && rx_level != 6'h00);
        next_tx_level = tx_level + 6'(tx_put) - 6'(tx_shift && tx_level != 6'h00);
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_level <= 6'h00;
            tx_level <= 6'h00;
        end else begin
            rx_level <= next_rx_level;
            tx_level <= next_tx_level;
        end
    end
    assign rx_push = rx_char;
    assign thr_empty = tx_level == 6'h00;
endmodule : uie_fifo_model
`default_nettype wire

// ---- uart_interrupt_enable_status_tb_top.sv ----
/*
 * Self-checking bench for the UART interrupt mask and source status core.
 * Assumes the FIFO fill model on the far side and the strobe register port.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module uart_interrupt_enable_status_tb_top;
    // Short character keeps the receive timeout span at 20 bit ticks
    localparam int CB = 2;
    localparam logic [2:0] A_RX = uie_pkg::ADDR_RX_DATA, A_MSK = uie_pkg::ADDR_MASK, A_SRC = uie_pkg::ADDR_SOURCE;
    localparam logic [2:0] A_FCR = uie_pkg::ADDR_FIFO_CTRL, A_LSR = uie_pkg::ADDR_LINE_STATUS;
    localparam logic [2:0] A_MSR = uie_pkg::ADDR_MODEM_STATUS, A_EMS = uie_pkg::ADDR_ENH_MODE;
    localparam logic [11:0] E_OVR = 12'h001, E_PERR = 12'h002, E_MATCH = 12'h004, E_SPEC = 12'h008;
    localparam logic [11:0] E_WAKE = 12'h010, E_RX = 12'h020, E_TXS = 12'h040, E_TICK = 12'h080, E_MDM = 12'h800;
    logic ref_clk, rstn, wr, rd, enh_enable, thr_empty, rx_push, irq, fifo_has_error;
    logic auto_rts, auto_cts, rts_pin, cts_pin, fifo_enable, sleep_enable, wake_int_enable;
    logic [2:0] addr, head_errors;
    logic [7:0] wdata, rdata, rv;
    logic [5:0] rx_level, tx_level;
    logic [1:0] rx_trig_sel, tx_trig_sel;
    logic [11:0] ev;
    int err_count, checks;
    ////////////////////////////////////////////////////////////
    uie_fifo_model fm (.ref_clk(ref_clk), .rstn(rstn), .rx_char(ev[5]), .rx_take(rd && addr == A_RX),
        .tx_put(wr && addr == A_RX), .tx_shift(ev[6]), .rx_level(rx_level), .rx_push(rx_push),
        .tx_level(tx_level), .thr_empty(thr_empty));
    uie_core #(.CHAR_BITS(CB), .LVL_W(6)) dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .enh_enable(enh_enable), .rx_level(rx_level), .tx_level(tx_level),
        .rx_push(rx_push), .rx_char_tick(1'b0), .bit_tick(ev[7]), .thr_empty(thr_empty),
        .tx_all_empty(thr_empty), .overrun_evt(ev[0]), .head_errors(head_errors), .push_errored(ev[1]),
        .fifo_has_error(fifo_has_error), .modem_changes(ev[11:8]), .char_match_evt(ev[2]),
        .special_char_evt(ev[3]), .auto_rts(auto_rts), .auto_cts(auto_cts), .rts_pin(rts_pin),
        .cts_pin(cts_pin), .wake_evt(ev[4]), .fifo_enable(fifo_enable), .rx_trig_sel(rx_trig_sel),
        .tx_trig_sel(tx_trig_sel), .sleep_enable(sleep_enable), .wake_int_enable(wake_int_enable), .irq(irq));
    ////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_clk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask : rd_reg
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        rd_reg(a);
        `CHK(rv, e)
    endtask : rd_chk
    // One-cycle event strobe, then an edge for sticky sources to land
    task automatic pulse(input logic [11:0] m);
        @(posedge ref_clk);
        ev <= m;
        @(posedge ref_clk);
        ev <= 12'h000;
        wait_clk(1);
    endtask : pulse
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(A_MSK, uie_pkg::MASK_RESET);
        rd_chk(A_SRC, 8'h01);
        `CHK(irq, 1'b0)
    endtask : t_reset
    task automatic t_mask();
        wr_reg(A_MSK, 8'hF0);
        rd_chk(A_MSK, 8'hF0);
        `CHK(sleep_enable, 1'b1)
        @(posedge ref_clk) enh_enable <= 1'b0;
        wr_reg(A_MSK, 8'h0D);
        rd_chk(A_MSK, 8'hFD);
        @(posedge ref_clk) enh_enable <= 1'b1;
        wr_reg(A_MSK, 8'h00);
    endtask : t_mask
    task automatic t_tx();
        wr_reg(A_MSK, 8'h02);
        wait_clk(1);
        `CHK(irq, 1'b1)
        rd_chk(A_SRC, 8'h02);
        `CHK(irq, 1'b0)
        wr_reg(A_RX, 8'h55);
        pulse(E_TXS);
        `CHK(irq, 1'b1)
        wr_reg(A_RX, 8'hAA);
        wait_clk(1);
        `CHK(irq, 1'b0)
        pulse(E_TXS);
        rd_chk(A_SRC, 8'h02);
    endtask : t_tx
    task automatic t_line_modem();
        wr_reg(A_MSK, 8'h0D);
        pulse(E_RX);
        rd_chk(A_SRC, 8'h04);
        pulse(E_OVR);
        rd_chk(A_SRC, 8'h06);
        rd_chk(A_LSR, 8'h63);
        rd_chk(A_SRC, 8'h04);
        rd_reg(A_RX);
        rd_chk(A_LSR, 8'h60);
        wr_reg(A_EMS, 8'h40);
        pulse(E_PERR);
        rd_chk(A_SRC, 8'h06);
        rd_reg(A_LSR);
        pulse(E_MDM);
        rd_chk(A_SRC, 8'h00);
        rd_reg(A_MSR);
        rd_chk(A_SRC, 8'h01);
        `CHK(irq, 1'b0)
    endtask : t_line_modem
    task automatic t_char_flow();
        wr_reg(A_MSK, 8'hE0);
        pulse(E_MATCH);
        rd_chk(A_SRC, 8'h10);
        rd_chk(A_SRC, 8'h01);
        pulse(E_SPEC);
        pulse(E_RX);
        `CHK(irq, 1'b0)
        rd_reg(A_RX);
        @(posedge ref_clk) cts_pin <= 1'b1;
        wait_clk(2);
        `CHK(irq, 1'b0)
        @(posedge ref_clk) auto_rts <= 1'b1;
        @(posedge ref_clk) rts_pin <= 1'b1;
        wait_clk(2);
        rd_chk(A_SRC, 8'h20);
        rd_reg(A_MSR);
        `CHK(irq, 1'b0)
        @(posedge ref_clk) cts_pin <= 1'b0;
        @(posedge ref_clk) auto_cts <= 1'b1;
        @(posedge ref_clk) cts_pin <= 1'b1;
        wait_clk(2);
        rd_chk(A_SRC, 8'h20);
        rd_reg(A_MSR);
    endtask : t_char_flow
    task automatic t_fifo_ctrl();
        wr_reg(A_MSK, 8'h00);
        wr_reg(A_FCR, 8'hF0);
        wait_clk(1);
        `CHK({fifo_enable, rx_trig_sel}, 3'b000)
        for (int i = 0; i < 4; i++) begin
            wr_reg(A_FCR, {i[1:0], i[1:0], 4'h1});
            wait_clk(1);
            `CHK({rx_trig_sel, tx_trig_sel}, {i[1:0], i[1:0]})
        end
        rd_chk(A_SRC, 8'hC1);
    endtask : t_fifo_ctrl
    task automatic t_rx_fifo();
        wr_reg(A_FCR, 8'h41);
        wr_reg(A_MSK, 8'h01);
        repeat (15) pulse(E_RX);
        `CHK(irq, 1'b0)
        pulse(E_RX);
        rd_chk(A_SRC, 8'hC4);
        rd_reg(A_RX);
        `CHK(irq, 1'b0)
        wr_reg(A_MSK, 8'h00);
        pulse(E_RX);
        `CHK(irq, 1'b0)
        rd_chk(A_LSR, 8'h61);
    endtask : t_rx_fifo
    task automatic t_timeout();
        wr_reg(A_FCR, 8'hC1);
        wr_reg(A_MSK, 8'h01);
        repeat (4 * CB + 11) pulse(E_TICK);
        `CHK(irq, 1'b0)
        pulse(E_TICK);
        rd_chk(A_SRC, 8'hCC);
        rd_reg(A_RX);
        `CHK(irq, 1'b0)
        repeat (15) rd_reg(A_RX);
        rd_chk(A_LSR, 8'h60);
    endtask : t_timeout
    task automatic t_wake_err();
        wr_reg(A_MSK, 8'h00);
        wr_reg(A_FCR, 8'h09);
        wait_clk(1);
        `CHK(wake_int_enable, 1'b1)
        pulse(E_WAKE);
        `CHK(irq, 1'b1)
        rd_chk(A_SRC, 8'hC1);
        `CHK(irq, 1'b0)
        @(posedge ref_clk) head_errors <= 3'b101;
        @(posedge ref_clk) fifo_has_error <= 1'b1;
        rd_chk(A_LSR, 8'hF4);
    endtask : t_wake_err
    // FIFO transmit path with the second trigger table entry
    task automatic t_tx_fifo();
        wr_reg(A_FCR, 8'h11);
        wr_reg(A_MSK, 8'h02);
        rd_chk(A_SRC, 8'hC2);
        repeat (8) wr_reg(A_RX, 8'h5A);
        wait_clk(1);
        `CHK(irq, 1'b0)
        pulse(E_TXS);
        `CHK(irq, 1'b1)
        rd_chk(A_SRC, 8'hC2);
        repeat (7) pulse(E_TXS);
        `CHK(irq, 1'b1)
    endtask : t_tx_fifo
    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        {rstn, wr, rd, fifo_has_error, auto_rts, auto_cts, rts_pin, cts_pin, addr, head_errors, wdata, ev} = '0;
        enh_enable = 1'b1;
        err_count = 0;
        checks = 0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_mask();
        t_tx();
        t_line_modem();
        t_char_flow();
        t_fifo_ctrl();
        t_rx_fifo();
        t_timeout();
        t_wake_err();
        t_tx_fifo();
        complete_run();
    end
    // Whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end
endmodule : uart_interrupt_enable_status_tb_top
`default_nettype wire
